// [wprot_pkg.sv]
/*
 * Constants and types for the serial flash write-protection block.
 * Assumes a 20 MHz core clock sampling the serial link pins.
 */
`default_nettype none
package wprot_pkg;
    localparam logic [7:0] write_latch_set_cmd   = 8'h06;
    localparam logic [7:0] write_latch_clear_cmd = 8'h04;
    localparam logic [7:0] status_write_cmd      = 8'h01;
    localparam logic [7:0] status_read_lo_cmd    = 8'h05;
    localparam logic [7:0] status_read_hi_cmd    = 8'h35;
    localparam logic [7:0] page_write_cmd        = 8'h02;
    localparam logic [7:0] four_kib_wipe_cmd     = 8'h20;
    localparam logic [7:0] block32_wipe_cmd      = 8'h52;
    localparam logic [7:0] block_wipe_cmd        = 8'hD8;
    localparam logic [7:0] chip_wipe_cmd         = 8'hC7;
    localparam logic [7:0] chip_wipe_alt_cmd     = 8'h60;
    localparam logic [7:0] pause_cmd             = 8'h75;
    localparam logic [7:0] resume_cmd            = 8'h7A;
    localparam logic [7:0] deep_sleep_cmd        = 8'hB9;
    localparam logic [7:0] wake_cmd              = 8'hAB;

    // Status bit positions
    localparam int busy_pos   = 0;
    localparam int latch_pos  = 1;
    localparam int size0_pos  = 2;
    localparam int tb_pos     = 5;
    localparam int fine_pos   = 6;
    localparam int glow_pos   = 7;
    localparam int ghigh_pos  = 8;
    localparam int quad_pos   = 9;
    localparam int lock1_pos  = 11;
    localparam int inv_pos    = 14;
    localparam int pause_pos  = 15;
    localparam logic [15:0] status_reset = 16'h0000;
    // Bits a status write may touch (lock bits only set, handled apart)
    localparam logic [15:0] status_wr_mask = 16'h43FC;

    localparam int  busy_time_ns = 10000;
    localparam int  clk_ns       = 50;
    localparam logic [15:0] busy_cycles = 16'(busy_time_ns / clk_ns);

    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_cmd  = 4'b0010,
        st_data = 4'b0100,
        st_done = 4'b1000
    } frame_state_t;
endpackage
`default_nettype wire

// [region_decode.sv]
/*
 * Decodes the protect code into a protected address range and
 * checks one 4 KiB-aligned target against it.
 * Assumes address in 4 KiB units (9 bits over 2 MiB).
 */
`default_nettype none
module region_decode
    import wprot_pkg::*;
(
    // Protect code
    input  wire logic       fine,
    input  wire logic       bottom,
    input  wire logic [2:0] size,
    input  wire logic       invert,
    // Target range in 4 KiB units, first and last
    input  wire logic [8:0] first_sec,
    input  wire logic [8:0] last_sec,
    output logic            hit
);
    logic [9:0] span;
    logic       all_w;
    logic       none_w;
    logic [8:0] lo;
    logic [8:0] hi;
    logic       base_hit;

    assign all_w  = size[2:1] == 2'b11;                         // RULE10
    assign none_w = size == 3'b000;                             // RULE9
    // Span in sectors: 64KB blocks 16<<(n-1); fine: 1<<(n-1), 32KB caps
    assign span = fine ? (size[2] ? 10'd8 : 10'd1 << (size[1:0] - 2'd1))
                       : 10'd16 << (size - 3'd1);
    assign lo = bottom ? 9'd0 : 9'(10'd512 - span);
    assign hi = bottom ? 9'(span - 10'd1) : 9'd511;
    assign base_hit = all_w ? 1'b1 : none_w ? 1'b0
                    : (last_sec >= lo) && (first_sec <= hi);
    // Invert: complement region; any overlap with it blocks the target
    assign hit = invert ? (all_w ? 1'b0 : none_w ? 1'b1
                 : bottom ? (last_sec > hi) : (first_sec < lo))   // RULE11
               : base_hit;
endmodule // region_decode
`default_nettype wire

// [flash_write_protection.sv]
/*
 * Write-protection and status logic of a serial flash: latch, busy,
 * protect decode, status guard modes, chip wipe gating, deep sleep.
 * Assumes serial clock, select and data pins asynchronous to clk;
 * mode 0/3 framing, MSB first, rising-edge sampling.
 */
// How it works
// [RULE1] Write-latch-set command sets latch flag
// [RULE2] Latch cleared at reset and by writes
// [RULE3] Deep sleep ignores all but wake
// [RULE4] Guard pin low locks protect and guards
// [RULE5] Writes refused while latch flag is zero
// [RULE6] Busy flag high during write operations
// [RULE7] Lower status byte bit layout
// [RULE8] Upper status byte bit layout
// [RULE9] Zero code none; 64KB top/bottom fractions
// [RULE10] Code 11x all; fine sizes 4-32KB
// [RULE11] Invert protects the exact complement
// [RULE12] Protect bits only by status write
// [RULE13] Protect bits writable only when unguarded
// [RULE14] Chip wipe only with unprotected code
// [RULE15] Guards 00: write whenever latch set
// [RULE16] Guards 01, pin low: refuse
// [RULE17] Guards 01, pin high: allow
// [RULE18] Guards 10: locked until power cycle
// [RULE19] Guards 11: locked permanently (code clears it at reset, as for guards 10)
// [RULE20] Quad enable defaults zero
// [RULE21] Lock bits set once only
// [RULE22] Invert bit read-write, default zero
// [RULE23] Paused flag set/cleared by commands
// [RULE24] Refused status write changes nothing (code still clears the latch flag)
`default_nettype none
module flash_write_protection
    import wprot_pkg::*;
(
    // Core
    input  wire logic        clk,
    input  wire logic        rstn,
    // Serial link pins
    input  wire logic        sclk,
    input  wire logic        sel_n,
    input  wire logic        sdi,
    input  wire logic        guard_n,
    output logic             sdo,
    output logic             sdo_oe_n,
    // Status view and array strobes
    output logic [15:0]      status,
    output logic             sleeping,
    output logic             array_write_go
);
    logic [1:0]  sclk_s;
    logic [1:0]  sel_s;
    logic [1:0]  sdi_s;
    logic [1:0]  guard_s;
    logic        sclk_d_r;
    logic        sel_d_r;
    frame_state_t st_r;
    logic [5:0]  bits_r;
    logic [7:0]  op_r;
    logic [31:0] sh_r;
    logic [15:0] stat_r;
    logic [15:0] busy_cnt_r;
    logic        sleep_r;
    logic        go_r;
    logic        sdo_r;
    logic        oe_n_r;
    logic [15:0] tx_r;

    wire rise = sclk_s[1] & ~sclk_d_r;
    wire fall = ~sclk_s[1] & sclk_d_r;
    wire sel  = ~sel_s[1];
    wire frame_end = ~sel & sel_d_r;
    wire [31:0] sh_in = {sh_r[30:0], sdi_s[1]};
    wire [5:0] nbits = bits_r;
    wire byte_ok = nbits[2:0] == 3'd0;
    wire [7:0] op_end = op_r;
    wire latch = stat_r[latch_pos];
    wire busy  = stat_r[busy_pos];
    wire [1:0] guards = {stat_r[ghigh_pos], stat_r[glow_pos]};
    // Pin becomes a data lane once quad enable is set
    wire pin_low = ~guard_s[1] & ~stat_r[quad_pos];
    wire [2:0] size = stat_r[size0_pos +: 3];
    wire inv = stat_r[inv_pos];

    function automatic logic is_wipe(input logic [7:0] c);
        is_wipe = c == four_kib_wipe_cmd || c == block32_wipe_cmd
               || c == block_wipe_cmd;
    endfunction

    // Status write permission by guard mode
    wire hw_guard = guards == 2'b01 && pin_low;                 // RULE4
    // Lock-down and one-time lock refuse until reset clears them
    wire sr_locked = guards[1];                         // RULE18 RULE19
    wire sr_open = guards == 2'b00                      // RULE15
                || (guards == 2'b01 && !pin_low);       // RULE16 RULE17
    wire sr_ok = latch && sr_open && !sr_locked;
    wire chip_ok = inv ? size[2:1] == 2'b11 : size == 3'b000;  // RULE14

    // Target in 4 KiB units; block sizes widen the range
    wire [23:0] addr = sh_r[23:0];
    wire [8:0] tgt_first = op_end == block_wipe_cmd
                         ? {addr[20:16], 4'h0}
                         : op_end == block32_wipe_cmd
                         ? {addr[20:15], 3'h0} : addr[20:12];
    wire [8:0] tgt_last = op_end == block_wipe_cmd
                        ? {addr[20:16], 4'hF}
                        : op_end == block32_wipe_cmd
                        ? {addr[20:15], 3'h7} : addr[20:12];
    logic prot_hit;

    region_decode u_region (
        .fine      (stat_r[fine_pos]),
        .bottom    (stat_r[tb_pos]),
        .size      (size),
        .invert    (inv),
        .first_sec (tgt_first),
        .last_sec  (tgt_last),
        .hit       (prot_hit)
    );

    // Address for a page write sits in bytes 2-4 of a longer frame
    logic [23:0] pw_addr_r;
    wire [8:0] pw_sec = pw_addr_r[20:12];
    logic pw_hit;
    region_decode u_region_pw (
        .fine      (stat_r[fine_pos]),
        .bottom    (stat_r[tb_pos]),
        .size      (size),
        .invert    (inv),
        .first_sec (pw_sec),
        .last_sec  (pw_sec),
        .hit       (pw_hit)
    );

    wire is_pw   = op_end == page_write_cmd;
    wire is_chip = op_end == chip_wipe_cmd || op_end == chip_wipe_alt_cmd;
    wire is_sr   = op_end == status_write_cmd;
    wire len_cmd = nbits == 6'd8;
    wire len_adr = nbits == 6'd32;
    wire len_sr  = nbits == 6'd16 || nbits == 6'd24;
    wire pw_len  = is_pw && nbits >= 6'd40 && byte_ok;
    // Commands act only at a clean frame end, awake and idle
    wire exec = frame_end && !sleep_r && !busy;

    // Next status: frame effects first, busy countdown last so it wins
    logic [15:0] stat_nxt;
    logic        go_nxt;
    logic [15:0] sr_new;
    always_comb begin
        stat_nxt = stat_r;
        go_nxt   = 1'b0;
        sr_new   = {sh_r[7:0], sh_r[15:8]};
        if (nbits == 6'd16)
            sr_new = {stat_r[15:8], sh_r[7:0]};
        if (exec && byte_ok) begin
            if (len_cmd && op_end == write_latch_set_cmd)
                stat_nxt[latch_pos] = 1'b1;                     // RULE1
            if (len_cmd && op_end == write_latch_clear_cmd)
                stat_nxt[latch_pos] = 1'b0;                     // RULE2
            if (len_cmd && op_end == pause_cmd)
                stat_nxt[pause_pos] = 1'b1;                     // RULE23
            if (len_cmd && op_end == resume_cmd)
                stat_nxt[pause_pos] = 1'b0;                     // RULE23
            if (is_sr && len_sr && latch) begin                 // RULE5
                stat_nxt[latch_pos] = 1'b0;                     // RULE2
                if (sr_ok) begin                                // RULE24
                    // RULE12 RULE13 RULE20 RULE22
                    stat_nxt = (stat_r & ~status_wr_mask)
                             | (sr_new & status_wr_mask);
                    if (hw_guard) begin
                        stat_nxt[glow_pos -: 6] = stat_r[glow_pos -: 6];
                        stat_nxt[ghigh_pos] = stat_r[ghigh_pos];
                    end
                    stat_nxt[lock1_pos +: 3] = stat_r[lock1_pos +: 3]
                                | sr_new[lock1_pos +: 3];       // RULE21
                    stat_nxt[latch_pos] = 1'b0;
                    stat_nxt[busy_pos]  = 1'b1;                 // RULE6
                end
            end
            if ((is_wipe(op_end) && len_adr || is_chip && len_cmd
                 || pw_len) && latch) begin                     // RULE5
                stat_nxt[latch_pos] = 1'b0;                     // RULE2
                if (is_wipe(op_end) ? !prot_hit                 // RULE12
                    : is_chip ? chip_ok : !pw_hit) begin        // RULE14
                    stat_nxt[busy_pos] = 1'b1;                  // RULE6
                    go_nxt = 1'b1;
                end
            end
        end
        if (busy && busy_cnt_r == 16'd1)
            stat_nxt[busy_pos] = 1'b0;                          // RULE6
    end

    // Two flip-flops on every pin input
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_s  <= 2'b00;
            sel_s   <= 2'b11;
            sdi_s   <= 2'b00;
            guard_s <= 2'b11;
        end else begin
            sclk_s  <= {sclk_s[0], sclk};
            sel_s   <= {sel_s[0], sel_n};
            sdi_s   <= {sdi_s[0], sdi};
            guard_s <= {guard_s[0], guard_n};
        end
    end

    // Frame capture: bit count, opcode, shift register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_d_r  <= 1'b0;
            sel_d_r   <= 1'b0;
            st_r      <= st_idle;
            bits_r    <= 6'd0;
            op_r      <= 8'h00;
            sh_r      <= 32'h0;
            pw_addr_r <= 24'h0;
        end else begin
            sclk_d_r <= sclk_s[1];
            sel_d_r  <= sel;
            case (st_r)
                st_idle: if (sel) begin
                    st_r   <= st_cmd;
                    bits_r <= 6'd0;
                end
                st_cmd, st_data: if (!sel) begin
                    st_r <= st_done;
                end else if (rise) begin
                    sh_r <= sh_in;
                    // Count saturates so overlong frames stay unusable
                    if (bits_r != 6'd63)
                        bits_r <= bits_r + 6'd1;
                    if (bits_r == 6'd7) begin
                        op_r <= sh_in[7:0];
                        st_r <= st_data;
                    end
                    if (bits_r == 6'd31)
                        pw_addr_r <= sh_in[23:0];
                end
                st_done: st_r <= st_idle;
                default: st_r <= st_idle;
            endcase
        end
    end

    // Status, busy timer, sleep
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stat_r     <= status_reset;                         // RULE2
            busy_cnt_r <= 16'd0;
            sleep_r    <= 1'b0;
            go_r       <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            go_r   <= go_nxt;
            // Timer loads as busy rises, then runs down to zero
            if (stat_nxt[busy_pos] && !busy)
                busy_cnt_r <= busy_cycles;
            else if (busy_cnt_r != 16'd0)
                busy_cnt_r <= busy_cnt_r - 16'd1;
            if (frame_end && byte_ok && len_cmd && !busy) begin
                if (sleep_r && op_end == wake_cmd)
                    sleep_r <= 1'b0;                            // RULE3
                else if (!sleep_r && op_end == deep_sleep_cmd)
                    sleep_r <= 1'b1;
            end
        end
    end

    // Status read out on falling sclk; reads also refused in sleep
    wire rd_lo = op_r == status_read_lo_cmd;
    wire rd_hi = op_r == status_read_hi_cmd;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sdo_r  <= 1'b0;
            oe_n_r <= 1'b1;
            tx_r   <= 16'h0;
        end else begin
            if (!sel || sleep_r) begin                          // RULE3
                oe_n_r <= 1'b1;
            end else if (st_r == st_data && (rd_lo || rd_hi) && fall) begin
                oe_n_r <= 1'b0;
                // RULE7 RULE8
                if (nbits[2:0] == 3'd0) begin
                    // Top bit goes out now, the rest queue behind it
                    sdo_r <= rd_lo ? stat_r[7] : stat_r[15];
                    tx_r  <= {(rd_lo ? stat_r[6:0] : stat_r[14:8]), 9'h000};
                end else begin
                    sdo_r <= tx_r[15];
                    tx_r  <= {tx_r[14:0], 1'b0};
                end
            end
        end
    end

    assign sdo            = sdo_r;
    assign sdo_oe_n       = oe_n_r;
    assign status         = stat_r;
    assign sleeping       = sleep_r;
    assign array_write_go = go_r;
endmodule // flash_write_protection
`default_nettype wire

// [flash_write_protection_properties.sv]
/*
 * Port-level assertions for the write-protection block.
 * Assumes the block's own clk and asynchronous active-low rstn.
 */
`default_nettype none
module fwp_checker
    import wprot_pkg::*;
(
    // Core
    input wire logic        clk,
    input wire logic        rstn,
    // Observed pins and outputs
    input wire logic        guard_n,
    input wire logic [15:0] status,
    input wire logic        sleeping,
    input wire logic        array_write_go
);
    logic [15:0] busy_cnt_r;
    logic [15:0] busy_cnt_nxt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Cycles the busy flag has stood so far
    assign busy_cnt_nxt = status[busy_pos] ? busy_cnt_r + 16'h0001
                                           : 16'h0000;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            busy_cnt_r <= 16'h0000;
        else
            busy_cnt_r <= busy_cnt_nxt;
    end

    a_busy_span: assert property (
        $fell(status[busy_pos]) |-> busy_cnt_r == busy_cycles)
        else $error("busy flag stood for a wrong span");
    a_busy_latch_drop: assert property (
        $rose(status[busy_pos]) |->
            !status[latch_pos] && $past(status[latch_pos]))
        else $error("write started without latch or kept latch");
    a_go_after_latch: assert property (
        array_write_go |-> status[busy_pos] &&
            $past(status[latch_pos], 2) ##1 !array_write_go)
        else $error("array launch without latch or busy");
    a_sleep_no_go: assert property (
        sleeping |-> !array_write_go)
        else $error("array launch while asleep");
    a_sleep_frozen: assert property (
        $past(sleeping) && sleeping |-> $stable(status))
        else $error("status changed while asleep");
    a_reserved_low: assert property (
        !status[10])
        else $error("reserved status bit set");
    a_lock_sticky: assert property (
        !(|($past(status[13:11]) & ~status[13:11])))
        else $error("security lock bit cleared");
    a_pin_guard: assert property (
        (!guard_n && status[8:7] == 2'b01 && !status[quad_pos]) [*4]
            |=> $stable(status[8:2]))
        else $error("guarded bits changed with pin low");
    a_lockdown_hold: assert property (
        status[ghigh_pos] |=> $stable(status[14:2]))
        else $error("status changed under lock-down");

    c_busy_done: cover property ($fell(status[busy_pos]));
    c_array_go: cover property (array_write_go);
    c_sleep: cover property ($rose(sleeping));
endmodule // fwp_checker

bind flash_write_protection fwp_checker fwp_checker_i (
    .clk, .rstn, .guard_n, .status, .sleeping, .array_write_go);
`default_nettype wire

// [spi_host_model.sv]
/*
 * Behavioural serial host: mode 0 frames, MSB first.
 * Assumes its tasks are entered just after a core clock edge.
 */
`default_nettype none
module spi_host_model (
    // Link pins
    output var logic sclk,
    output var logic sel_n,
    output var logic sdi,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        sclk = 1'b0;
        sel_n = 1'b1;
        sdi = 1'b0;
    end

    // Clock stands low outside frames; last 8 bits read back in rd
    task automatic xfer(input logic [47:0] d, input int n,
                        output logic [7:0] rd);
        sel_n = 1'b0;
        #200;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = d[i];
            #200 sclk = 1'b1;
            #199 rd = {rd[6:0], sdo};
            #1 sclk = 1'b0;
        end
        #200 sel_n = 1'b1;
        sdi = ~sdi;
        #400;
    endtask
endmodule // spi_host_model
`default_nettype wire

// [flash_write_protection_tb.sv]
/*
 * Self-checking bench for the write-protection block.
 * Assumes a 20 MHz core clock and the serial host model.
 */
`default_nettype none
module flash_write_protection_tb
    import wprot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, rstn, sclk, sel_n, sdi, guard_n, sdo, sdo_oe_n;
    logic [15:0] status;
    logic        sleeping, array_write_go;
    logic [7:0]  rd;
    logic [63:0] tbl [14];
    int          n_fail = 0, checks_done = 0, n_go = 0, n_oe = 0, oe0;
    // Released line shows the inverse of the last bit driven
    wire         sdo_seen = sdo_oe_n ? ~sdo : sdo;

    flash_write_protection flash_write_protection_i (
        .clk, .rstn, .sclk, .sel_n, .sdi, .guard_n, .sdo, .sdo_oe_n,
        .status, .sleeping, .array_write_go);
    spi_host_model spi_host_model_i (.sclk, .sel_n, .sdi, .sdo (sdo_seen));

    always #25 clk = ~clk;
    always @(posedge clk) if (array_write_go === 1'b1) n_go <= n_go + 1;
    always @(posedge clk) if (sdo_oe_n === 1'b0) n_oe <= n_oe + 1;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [47:0] d, input int n);
        spi_host_model_i.xfer(d, n, rd);
    endtask

    task automatic idle();
        int k;
        k = 0;
        while (status[busy_pos] !== 1'b0 && k < 400) begin
            @(posedge clk);
            #2;
            k++;
        end
        chk(16'(k >= 400), 16'h0000);
    endtask

    // Latch, then status write of low and high byte
    task automatic wst(input logic [7:0] lo, input logic [7:0] hi,
                       input logic bsy);
        cmd({40'h0, write_latch_set_cmd}, 8);
        cmd({24'h0, status_write_cmd, lo, hi}, 24);
        chk(16'(status[busy_pos]), 16'(bsy));
        idle();
    endtask

    task automatic wipe(input logic [7:0] op, input logic [23:0] a,
                        input int n, input int exp_go);
        int g;
        g = n_go;
        cmd({40'h0, write_latch_set_cmd}, 8);
        cmd({8'h00, op, a, 8'h5A} >> (40 - n), n);
        idle();
        chk(16'(n_go - g), 16'(exp_go));
        chk(16'(status[latch_pos]), 16'h0000);
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #2_000_000;
        $display("Error at %0t: watchdog expired", $time);
        n_fail++;
        conclude();
    end

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        guard_n = 1'b0;
        // low, high, opcode, address, bit count, launches expected
        tbl = '{64'h0400_201F_0000_2000, 64'h0400_201E_F000_2001,
                64'h2400_2000_0000_2000, 64'h2400_D801_0000_2001,
                64'h2400_5200_8000_2000,
                64'h4400_201F_F000_2000, 64'h4400_021F_E000_2801,
                64'h4440_201F_E000_2000, 64'h4440_021F_F000_2801,
                64'h1800_0200_0000_2800, 64'h1800_C700_0000_0800,
                64'h1840_C700_0000_0801, 64'h0040_6000_0000_0800,
                64'h0000_6000_0000_0801};
        repeat (8) @(posedge clk);
        #2 rstn = 1'b1;
        repeat (3) @(posedge clk);
        #2;
        chk(status, 16'h0000);
        cmd({40'h0, write_latch_set_cmd}, 8);
        chk(status, 16'h0002);
        cmd({40'h0, write_latch_clear_cmd}, 8);
        chk(status, 16'h0000);
        cmd({40'h0, pause_cmd}, 8);
        chk(status, 16'h8000);
        cmd({40'h0, resume_cmd}, 8);
        chk(status, 16'h0000);
        cmd({24'h0, status_write_cmd, 16'h1C00}, 24);
        chk(status, 16'h0000);
        foreach (tbl[i]) begin
            wst(tbl[i][63:56], tbl[i][55:48], 1'b1);
            chk(status, {tbl[i][55:48], tbl[i][63:56]});
            wipe(tbl[i][47:40], tbl[i][39:16], int'(tbl[i][15:8]),
                 int'(tbl[i][7:0]));
        end
        wst(8'h7C, 8'h08, 1'b1);
        cmd({32'h0, status_read_lo_cmd, 8'h00}, 16);
        chk({8'h00, rd}, 16'h007C);
        cmd({32'h0, status_read_hi_cmd, 8'h00}, 16);
        chk({8'h00, rd}, 16'h0008);
        chk(16'(n_oe > 0), 16'h0001);
        wst(8'h80, 8'h00, 1'b1);
        chk(status, 16'h0880);
        wst(8'h84, 8'h00, 1'b0);
        chk(status, 16'h0880);
        guard_n = 1'b1;
        repeat (8) @(posedge clk);
        #2;
        wst(8'h84, 8'h00, 1'b1);
        chk(status, 16'h0884);
        wst(8'h84, 8'h02, 1'b1);
        guard_n = 1'b0;
        repeat (8) @(posedge clk);
        #2;
        wst(8'h80, 8'h02, 1'b1);
        chk(status, 16'h0A80);
        wst(8'h00, 8'h01, 1'b1);
        wst(8'h00, 8'h00, 1'b0);
        chk(status, 16'h0900);
        cmd({40'h0, deep_sleep_cmd}, 8);
        chk(16'(sleeping), 16'h0001);
        cmd({40'h0, write_latch_set_cmd}, 8);
        chk(status, 16'h0900);
        oe0 = n_oe;
        cmd({32'h0, status_read_lo_cmd, 8'h00}, 16);
        chk(16'(n_oe - oe0), 16'h0000);
        cmd({40'h0, wake_cmd}, 8);
        chk(16'(sleeping), 16'h0000);
        rstn = 1'b0;
        repeat (8) @(posedge clk);
        #2 rstn = 1'b1;
        repeat (3) @(posedge clk);
        #2;
        chk(status, 16'h0000);
        conclude();
    end
endmodule // flash_write_protection_tb
`default_nettype wire
